/* inc/fur_pkg.sv */
// Shared constants and types for the flash unlock, reset and power-down command block
package fur_pkg;
    // Instruction codes
    localparam logic [7:0] OP_PASSWORD_UNLOCK = 8'hEA;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_SOFT_RESET = 8'h99;
    localparam logic [7:0] OP_MODE_BITS_CLEAR = 8'hFF;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE_AND_ID = 8'hAB;
    // Frame lengths in serial clock edges
    localparam logic [6:0] OP_EDGES_SINGLE = 7'h08;
    localparam logic [6:0] OP_EDGES_QUAD = 7'h02;
    localparam logic [6:0] PW_EDGES_SINGLE = 7'h48;
    localparam logic [6:0] PW_EDGES_QUAD = 7'h12;
    localparam logic [6:0] ID_START_SINGLE = 7'h20;
    localparam logic [6:0] ID_START_QUAD = 7'h08;
    localparam logic [6:0] MBR_EDGES = 7'h08;
    localparam logic [6:0] CNT_MAX = 7'h7F;
    localparam logic [6:0] CNT_ONE = 7'h01;
    // Configuration register 1 field positions and reset values
    localparam int CFG1_SRP_POS = 0;
    localparam logic [7:0] CFG1_RESET = 8'h00;
    localparam logic LOCK_POR_VALUE = 1'b0;
    // Output lane enables
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_QUAD = 4'hF;
    localparam logic [3:0] OE_NONE = 4'h0;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int NS_PER_US = 1000;
    localparam int TMR_W = 24;

    // Least time in ns to whole clock cycles, never below one
    function automatic int fur_min_cycles(input int t_ns);
        int c;
        c = (t_ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
        return (c < 1) ? 1 : c;
    endfunction

    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_READY,
        ST_COMPARE,
        ST_ERROR,
        ST_RECOVER,
        ST_SLEEP_ENTRY,
        ST_SLEEP,
        ST_WAKE
    } fur_state_t;

    // Serial-clock domain state
    typedef struct packed {
        logic quad_s1;
        logic quad_s2;
        logic busy_s1;
        logic busy_s2;
        logic [6:0] cnt;
        logic [7:0] op;
        logic [63:0] sh;
        logic mbr_ones;
        logic tog;
    } fur_link_t;

    // System-clock domain state
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        fur_state_t st;
        logic [TMR_W-1:0] tmr;
        logic write_in_progress_flag;
        logic perr;
        logic lock;
        logic match;
        logic rst_en;
        logic por_done;
        logic soft_pulse;
        logic xip_pulse;
        logic [7:0] cfg1;
        logic seen;
    } fur_core_t;
endpackage

/* logic/fur_cmd.sv */
// Unlock, reset, mode-bit reset, deep power-down and wake/ID command handling
// Functional notes
// - Unlock runs only when chip select rises right after bit 72.
// - Valid unlock starts timed compare; write-in-progress high until it completes.
// - Password mismatch sets program error and leaves write-in-progress stuck high.
// - Only clear-status, 66h-99h reset or hardware reset clear the error state.
// - Matching password sets the protection lock bit when the compare ends.
// - Quad command mode carries instruction and data four bits per clock.
// - Software reset reloads volatile registers from their nonvolatile defaults.
// - Software reset keeps status-protect bit and protection lock; hardware reset restores.
// - Software reset acts at chip select rise, then waits the recovery time.
// - Reset before power-up completed runs a full power-up sequence.
// - 99h is taken only directly after 66h; any other command cancels enable.
// - Mode-bit reset is eight ones on IO0, other lanes ignored; exits continuous read.
// - B9h with chip select rise after bit eight enters sleep after entry time.
// - While asleep only the wake and ID command is recognised.
// - Hardware reset in sleep runs power-on reset; power-up is never asleep.
// - ABh wakes the device; no command accepted until the wake time ends.
// - ID read: ABh, three dummy bytes, ID MSb first on falling edges.
// - Wake and ID command is ignored while another operation is busy.
// - Quad command mode returns the ID four bits per clock.
module fur_cmd
    import fur_pkg::*;
#(
    parameter int POWER_UP_TIME_NS = 300000,
    parameter int RESET_RECOVERY_TIME_NS = 30000,
    parameter int SLEEP_ENTRY_TIME_NS = 3000,
    parameter int WAKE_TIME_NS = 30000,
    parameter int COMPARE_TIME_NS = 10000,
    parameter logic [7:0] CLEAR_STATUS_OPCODE = 8'h30,
    // Arbitrary identification value
    parameter logic [7:0] DEVICE_ID = 8'h5A
)
(
    input wire logic clk_in,                     // System clock
    input wire logic rst_in,                     // Hardware reset, active high
    input wire logic sclk_in,                    // Serial clock from host
    input wire logic cs_n_in,                    // Chip select, active low
    input wire logic [3:0] io_in,                // Data lanes in
    output logic [3:0] io_out,                   // Data lanes out
    output logic [3:0] io_oe_out,                // Lane drive enables
    input wire logic quad_command_mode_in,       // Four-lane command mode
    input wire logic busy_in,                    // Erase/program/write busy
    input wire logic [63:0] stored_password_in,  // Hidden password
    input wire logic [7:0] cfg1_default_in,      // Nonvolatile default of cfg reg 1
    input wire logic cfg1_wr_in,                 // Write strobe for cfg reg 1
    input wire logic [7:0] cfg1_wdata_in,        // Write data for cfg reg 1
    output logic [7:0] volatile_config_reg1_out, // Volatile cfg reg 1
    output logic status_protect_volatile_bit_out,// Cfg reg 1 bit 0
    output logic write_in_progress_flag_out,     // Write in progress
    output logic program_error_out,              // Program error flag
    output logic protection_lock_bit_out,        // Protection lock
    output logic deep_sleep_out,                 // In deep power-down
    output logic ready_out,                      // Accepting commands
    output logic soft_reset_out,                 // Volatile reload pulse
    output logic mode_bits_clear_out             // Continuous read exit pulse
);
    localparam logic [TMR_W-1:0] PU_CYC = TMR_W'(fur_min_cycles(POWER_UP_TIME_NS) - 1);
    localparam logic [TMR_W-1:0] RPH_CYC = TMR_W'(fur_min_cycles(RESET_RECOVERY_TIME_NS) - 1);
    localparam logic [TMR_W-1:0] DP_CYC = TMR_W'(fur_min_cycles(SLEEP_ENTRY_TIME_NS) - 1);
    localparam logic [TMR_W-1:0] RES_CYC = TMR_W'(fur_min_cycles(WAKE_TIME_NS) - 1);
    localparam logic [TMR_W-1:0] CMP_CYC = TMR_W'(fur_min_cycles(COMPARE_TIME_NS) - 1);

    fur_link_t lk_q;
    fur_link_t lk_d;
    fur_core_t cr_q;
    fur_core_t cr_d;
    logic fresh_q;
    logic [3:0] io_q;
    logic [3:0] oe_q;
    logic [3:0] io_d;
    logic [3:0] oe_d;

    // ---------------- Serial clock domain ----------------

    // Marks the first edge of a frame; set while chip select is high
    always_ff @(posedge sclk_in or posedge cs_n_in or posedge rst_in)
    begin
        if (rst_in || cs_n_in)
        begin
            fresh_q <= 1'b1;
        end
        else
        begin
            fresh_q <= 1'b0;
        end
    end

    always_comb
    begin
        logic [6:0] base;
        base = fresh_q ? 7'h00 : lk_q.cnt;
        lk_d = lk_q;
        lk_d.quad_s1 = quad_command_mode_in;
        lk_d.quad_s2 = lk_q.quad_s1;
        lk_d.busy_s1 = cr_q.write_in_progress_flag | busy_in;
        lk_d.busy_s2 = lk_q.busy_s1;
        lk_d.cnt = (base == CNT_MAX) ? CNT_MAX : base + CNT_ONE;
        // Frame marker toggles once per frame that saw a clock edge
        if (fresh_q)
        begin
            lk_d.tog = ~lk_q.tog;
        end
        if (lk_q.quad_s2)
        begin
            lk_d.sh = {lk_q.sh[59:0], io_in};
        end
        else
        begin
            lk_d.sh = {lk_q.sh[62:0], io_in[0]};
        end
        if (lk_d.cnt == (lk_q.quad_s2 ? OP_EDGES_QUAD : OP_EDGES_SINGLE))
        begin
            lk_d.op = lk_d.sh[7:0];
        end
        if (fresh_q)
        begin
            lk_d.mbr_ones = io_in[0];
        end
        else if (lk_d.cnt <= MBR_EDGES)
        begin
            lk_d.mbr_ones = lk_q.mbr_ones & io_in[0];
        end
    end

    always_ff @(posedge sclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lk_q <= '0;
        end
        else
        begin
            lk_q <= lk_d;
        end
    end

    // ID shifter on falling edges
    always_comb
    begin
        logic [6:0] idx;
        logic [6:0] start;
        start = lk_q.quad_s2 ? ID_START_QUAD : ID_START_SINGLE;
        idx = lk_q.cnt - start;
        io_d = 4'h0;
        oe_d = OE_NONE;
        if (!fresh_q && lk_q.op == OP_WAKE_AND_ID && !lk_q.busy_s2 && lk_q.cnt >= start)
        begin
            if (lk_q.quad_s2)
            begin
                oe_d = OE_QUAD;
                if (idx == 7'h00)
                begin
                    io_d = DEVICE_ID[7:4];
                end
                else if (idx == 7'h01)
                begin
                    io_d = DEVICE_ID[3:0];
                end
            end
            else
            begin
                oe_d = OE_SINGLE;
                if (idx < 7'h08)
                begin
                    io_d[1] = DEVICE_ID[3'h7 - idx[2:0]];
                end
            end
        end
    end

    always_ff @(negedge sclk_in or posedge cs_n_in or posedge rst_in)
    begin
        if (rst_in || cs_n_in)
        begin
            io_q <= 4'h0;
            oe_q <= OE_NONE;
        end
        else
        begin
            io_q <= io_d;
            oe_q <= oe_d;
        end
    end

    assign io_out = io_q;
    assign io_oe_out = oe_q;

    // ---------------- System clock domain ----------------

    always_comb
    begin
        logic frame_end;
        logic quad;
        logic [6:0] op_len;
        logic [6:0] pw_len;
        logic op_only;
        logic tmr_done;
        logic reset_ok;
        logic [63:0] pw;
        cr_d = cr_q;
        cr_d.cs_s1 = cs_n_in;
        cr_d.cs_s2 = cr_q.cs_s1;
        cr_d.cs_s3 = cr_q.cs_s2;
        cr_d.soft_pulse = 1'b0;
        cr_d.xip_pulse = 1'b0;
        // Link words are frozen once chip select is high, so reading them here is safe
        frame_end = cr_q.cs_s2 & ~cr_q.cs_s3 & (lk_q.tog != cr_q.seen);
        if (cr_q.cs_s2 & ~cr_q.cs_s3)
        begin
            cr_d.seen = lk_q.tog;
        end
        quad = quad_command_mode_in;
        op_len = quad ? OP_EDGES_QUAD : OP_EDGES_SINGLE;
        pw_len = quad ? PW_EDGES_QUAD : PW_EDGES_SINGLE;
        op_only = (lk_q.cnt == op_len);
        tmr_done = (cr_q.tmr == '0);
        for (int i = 0; i < 8; i++)
        begin
            pw[8*i +: 8] = lk_q.sh[56-8*i +: 8];
        end
        if (!tmr_done)
        begin
            cr_d.tmr = cr_q.tmr - 1'b1;
        end
        if (cfg1_wr_in && cr_q.st != ST_POWER_UP)
        begin
            cr_d.cfg1 = cfg1_wdata_in;
        end

        case (cr_q.st)
            ST_POWER_UP:
            begin
                if (tmr_done)
                begin
                    cr_d.cfg1 = cfg1_default_in;
                    cr_d.por_done = 1'b1;
                    cr_d.st = ST_READY;
                end
            end
            ST_COMPARE:
            begin
                if (tmr_done)
                begin
                    if (cr_q.match)
                    begin
                        cr_d.lock = 1'b1;
                        cr_d.write_in_progress_flag = 1'b0;
                        cr_d.st = ST_READY;
                    end
                    else
                    begin
                        cr_d.perr = 1'b1;
                        cr_d.st = ST_ERROR;
                    end
                end
            end
            ST_RECOVER:
            begin
                if (tmr_done)
                begin
                    cr_d.st = ST_READY;
                end
            end
            ST_SLEEP_ENTRY:
            begin
                if (tmr_done)
                begin
                    cr_d.st = ST_SLEEP;
                end
            end
            ST_WAKE:
            begin
                if (tmr_done)
                begin
                    cr_d.st = ST_READY;
                end
            end
            default:
            begin
            end
        endcase

        reset_ok = (cr_q.st == ST_READY) || (cr_q.st == ST_ERROR) ||
                   (cr_q.st == ST_COMPARE) || (cr_q.st == ST_POWER_UP);
        if (frame_end)
        begin
            if (cr_q.st == ST_SLEEP)
            begin
                if (lk_q.op == OP_WAKE_AND_ID && lk_q.cnt >= op_len)
                begin
                    cr_d.st = ST_WAKE;
                    cr_d.tmr = RES_CYC;
                end
            end
            else if (reset_ok)
            begin
                cr_d.rst_en = op_only && lk_q.op == OP_RESET_ENABLE;
                if (op_only && lk_q.op == OP_SOFT_RESET && cr_q.rst_en)
                begin
                    cr_d.perr = 1'b0;
                    cr_d.write_in_progress_flag = 1'b0;
                    cr_d.soft_pulse = 1'b1;
                    cr_d.cfg1 = {cfg1_default_in[7:1], cr_q.cfg1[CFG1_SRP_POS]};
                    if (cr_q.por_done)
                    begin
                        cr_d.st = ST_RECOVER;
                        cr_d.tmr = RPH_CYC;
                    end
                    else
                    begin
                        cr_d.st = ST_POWER_UP;
                        cr_d.tmr = PU_CYC;
                    end
                end
                else if (op_only && lk_q.op == CLEAR_STATUS_OPCODE && cr_q.st != ST_COMPARE &&
                         cr_q.st != ST_POWER_UP)
                begin
                    cr_d.perr = 1'b0;
                    cr_d.write_in_progress_flag = 1'b0;
                    cr_d.st = ST_READY;
                end
                else if (cr_q.st == ST_READY)
                begin
                    if (lk_q.cnt == MBR_EDGES && lk_q.mbr_ones)
                    begin
                        cr_d.xip_pulse = 1'b1;
                    end
                    if (lk_q.cnt == pw_len && lk_q.op == OP_PASSWORD_UNLOCK && !busy_in)
                    begin
                        cr_d.st = ST_COMPARE;
                        cr_d.write_in_progress_flag = 1'b1;
                        cr_d.tmr = CMP_CYC;
                        cr_d.match = (pw == stored_password_in);
                    end
                    else if (op_only && lk_q.op == OP_DEEP_SLEEP && !busy_in)
                    begin
                        cr_d.st = ST_SLEEP_ENTRY;
                        cr_d.tmr = DP_CYC;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cr_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, st: ST_POWER_UP, tmr: PU_CYC,
                      write_in_progress_flag: 1'b0, perr: 1'b0, lock: LOCK_POR_VALUE, match: 1'b0, rst_en: 1'b0,
                      por_done: 1'b0, soft_pulse: 1'b0, xip_pulse: 1'b0, cfg1: CFG1_RESET,
                      seen: 1'b0};
        end
        else
        begin
            cr_q <= cr_d;
        end
    end

    assign volatile_config_reg1_out = cr_q.cfg1;
    assign status_protect_volatile_bit_out = cr_q.cfg1[CFG1_SRP_POS];
    assign write_in_progress_flag_out = cr_q.write_in_progress_flag;
    assign program_error_out = cr_q.perr;
    assign protection_lock_bit_out = cr_q.lock;
    assign deep_sleep_out = (cr_q.st == ST_SLEEP);
    assign ready_out = (cr_q.st == ST_READY);
    assign soft_reset_out = cr_q.soft_pulse;
    assign mode_bits_clear_out = cr_q.xip_pulse;
endmodule

/* tb/fur_cmd_properties.sv */
// Concurrent checks on the unlock, reset and power-down command block
module fur_cmd_properties
    import fur_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic quad_command_mode_in,
    input wire logic [3:0] io_oe_out,
    input wire logic status_protect_volatile_bit_out,
    input wire logic write_in_progress_flag_out,
    input wire logic program_error_out,
    input wire logic protection_lock_bit_out,
    input wire logic deep_sleep_out,
    input wire logic ready_out,
    input wire logic soft_reset_out,
    input wire logic mode_bits_clear_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    wip_blocks_a: assert property (write_in_progress_flag_out |-> !ready_out)
        else $error("ready while write in progress");
    err_keeps_wip_a: assert property (program_error_out |-> write_in_progress_flag_out)
        else $error("error without write in progress");
    err_clear_a: assert property ($fell(program_error_out) |-> !write_in_progress_flag_out)
        else $error("error cleared but write in progress kept");
    lock_on_end_a: assert property ($rose(protection_lock_bit_out) |->
        $past(write_in_progress_flag_out) && !program_error_out)
        else $error("lock set outside a good compare end");
    soft_keeps_a: assert property (soft_reset_out |-> ($stable(protection_lock_bit_out)
        && $stable(status_protect_volatile_bit_out)) ##1 ($stable(protection_lock_bit_out)
        && $stable(status_protect_volatile_bit_out)))
        else $error("soft reset changed lock or protect bit");
    soft_clears_a: assert property (soft_reset_out |-> ##[0:1] (!program_error_out
        && !write_in_progress_flag_out && !ready_out))
        else $error("soft reset did not clear flags");
    sleep_quiet_a: assert property (deep_sleep_out |-> !ready_out && io_oe_out == OE_NONE)
        else $error("activity while asleep");
    lane_mode_a: assert property (io_oe_out != OE_NONE |->
        io_oe_out == (quad_command_mode_in ? OE_QUAD : OE_SINGLE))
        else $error("wrong lanes driven");
    idle_off_a: assert property (cs_n_in |-> io_oe_out == OE_NONE)
        else $error("lanes driven while deselected");
    mbr_pulse_a: assert property (mode_bits_clear_out |=> !mode_bits_clear_out)
        else $error("mode clear pulse too long");

    cover property ($rose(protection_lock_bit_out));
    cover property ($rose(program_error_out));
    cover property ($rose(deep_sleep_out));
    cover property (soft_reset_out);
endmodule

bind fur_cmd fur_cmd_properties fur_cmd_properties_inst (.clk_in, .rst_in, .cs_n_in,
    .quad_command_mode_in, .io_oe_out, .status_protect_volatile_bit_out,
    .write_in_progress_flag_out, .program_error_out, .protection_lock_bit_out, .deep_sleep_out,
    .ready_out, .soft_reset_out, .mode_bits_clear_out);

/* tb/fur_host_model.sv */
// Host controller model sending command frames on its own serial clock
module fur_host_model
    import fur_pkg::*;
(
    input wire logic quad_in,       // Four-lane command mode
    input wire logic [3:0] io_in,   // Resolved lane levels
    output logic sclk_out,          // Serial clock, idle low
    output logic cs_n_out,          // Chip select
    output logic [3:0] io_out       // Host lane drive
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        io_out = 4'h0;
    end

    // Lanes the host does not drive show the inverse of their last value
    task automatic frame(input logic [7:0] b[$], input int rd_n, output logic [7:0] rd);
        int w;
        logic [7:0] v;
        w = quad_in ? 4 : 1;
        rd = 8'h00;
        cs_n_out = 1'b0;
        #3;
        foreach (b[i])
        begin
            v = b[i];
            for (int k = 8 - w; k >= 0; k -= w)
            begin
                io_out = (w == 4) ? 4'(v >> k) : {~io_out[3:1], v[k]};
                #3 sclk_out = 1'b1;
                #3 sclk_out = 1'b0;
            end
        end
        repeat (rd_n * 8 / w)
        begin
            io_out = ~io_out;
            #3 sclk_out = 1'b1;
            rd = quad_in ? {rd[3:0], io_in} : {rd[6:0], io_in[1]};
            #3 sclk_out = 1'b0;
        end
        // chip select held high past the chip select synchroniser and frame-end decode
        #3 cs_n_out = 1'b1;
        #30;
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the unlock, reset and power-down command block
module tb_top
    import fur_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID_VAL = 8'hC3; // Arbitrary identification value
    logic clk_in, rst_in, quad_command_mode_in, busy_in, cfg1_wr_in, sclk_in, cs_n_in;
    logic [7:0] cfg1_default_in, cfg1_wdata_in, volatile_config_reg1_out, def, wdat, rd;
    logic [63:0] stored_password_in;
    logic [3:0] io_in, io_out, io_oe_out, host_io;
    logic write_in_progress_flag_out, program_error_out, protection_lock_bit_out;
    logic deep_sleep_out, ready_out, soft_reset_out, mode_bits_clear_out;
    logic status_protect_volatile_bit_out;
    logic [10:0] exp_q[$];
    int num_errors = 0, num_checks = 0, n_soft = 0, n_mbr = 0, n_oe = 0, oe_base = 0;
    logic [2:0] flags;

    assign flags = {deep_sleep_out, program_error_out, ready_out};

    assign io_in = (io_oe_out & io_out) | (~io_oe_out & host_io);

    fur_cmd #(.POWER_UP_TIME_NS(50), .RESET_RECOVERY_TIME_NS(50), .SLEEP_ENTRY_TIME_NS(50),
        .WAKE_TIME_NS(50), .COMPARE_TIME_NS(50), .DEVICE_ID(ID_VAL)) fur_cmd_inst (.clk_in,
        .rst_in, .sclk_in, .cs_n_in, .io_in, .io_out, .io_oe_out, .quad_command_mode_in,
        .busy_in, .stored_password_in, .cfg1_default_in, .cfg1_wr_in, .cfg1_wdata_in,
        .volatile_config_reg1_out, .status_protect_volatile_bit_out,
        .write_in_progress_flag_out, .program_error_out, .protection_lock_bit_out,
        .deep_sleep_out, .ready_out, .soft_reset_out, .mode_bits_clear_out);
    fur_host_model fur_host_model_inst (.quad_in(quad_command_mode_in), .io_in,
        .sclk_out(sclk_in), .cs_n_out(cs_n_in), .io_out(host_io));

    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic check_val(input logic [10:0] got, input logic [10:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors=%0d checks=%0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Flag select: 0 ready, 1 program error, 2 deep sleep
    task automatic wait_hi(input int sel);
        int n;
        n = 0;
        while (n < 400 && flags[sel] !== 1'b1)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n == 400)
            num_errors++;
    endtask

    task automatic send(input logic [7:0] b[$]);
        fur_host_model_inst.frame(b, 0, rd);
    endtask

    task automatic unlock(input logic [63:0] p);
        logic [7:0] q[$];
        q = {OP_PASSWORD_UNLOCK};
        for (int i = 0; i < 8; i++)
            q.push_back(p[8*i+:8]);
        send(q);
    endtask

    always @(posedge clk_in)
    begin
        n_soft <= n_soft + int'(soft_reset_out === 1'b1);
        n_mbr <= n_mbr + int'(mode_bits_clear_out === 1'b1);
        n_oe <= n_oe + int'((|io_oe_out) === 1'b1);
    end

    // Each rise of ready or error takes the oldest noted state
    always @(posedge ready_out or posedge program_error_out)
    begin
        #1;
        check_val({write_in_progress_flag_out, program_error_out, protection_lock_bit_out,
            volatile_config_reg1_out}, (exp_q.size() > 0) ? exp_q.pop_front() : 11'h7FF);
    end

    initial
    begin
        #40us;
        num_errors++;
        stop_test();
    end

    initial
    begin
        rst_in = 1'b1;
        quad_command_mode_in = 1'b0;
        busy_in = 1'b0;
        cfg1_wr_in = 1'b0;
        cfg1_wdata_in = 8'h00;
        void'($urandom(13));
        stored_password_in = {$urandom, $urandom};
        def = 8'($urandom) & 8'hFE;
        wdat = 8'($urandom) | 8'h01;
        cfg1_default_in = def;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        exp_q.push_back({3'b000, def});
        wait_hi(0);
        fur_host_model_inst.frame('{OP_WAKE_AND_ID, 8'h00, 8'h00, 8'h00}, 1, rd);
        check_val(11'(rd), 11'(ID_VAL));
        busy_in <= 1'b1;
        oe_base = n_oe;
        fur_host_model_inst.frame('{OP_WAKE_AND_ID, 8'h00, 8'h00, 8'h00}, 1, rd);
        check_val(11'(n_oe - oe_base), 11'h000);
        busy_in <= 1'b0;
        fur_host_model_inst.frame('{OP_WAKE_AND_ID, 8'h00, 8'h00, 8'h00}, 1, rd);
        check_val(11'(rd), 11'(ID_VAL));
        exp_q.push_back({3'b110, def});
        unlock(stored_password_in ^ 64'h1);
        wait_hi(1);
        exp_q.push_back({3'b000, def});
        send('{8'h30});
        wait_hi(0);
        send('{OP_RESET_ENABLE});
        send('{8'h05});
        send('{OP_SOFT_RESET});
        check_val(11'(n_soft), 11'h000);
        send('{OP_MODE_BITS_CLEAR});
        check_val(11'(n_mbr), 11'h001);
        exp_q.push_back({3'b110, def});
        unlock(~stored_password_in);
        wait_hi(1);
        exp_q.push_back({3'b000, def});
        send('{OP_MODE_BITS_CLEAR});
        send('{OP_RESET_ENABLE});
        send('{OP_SOFT_RESET});
        wait_hi(0);
        check_val(11'(n_soft), 11'h001);
        @(posedge clk_in);
        cfg1_wr_in <= 1'b1;
        cfg1_wdata_in <= wdat;
        quad_command_mode_in <= 1'b1;
        @(posedge clk_in);
        cfg1_wr_in <= 1'b0;
        send('{8'h00});
        exp_q.push_back({3'b001, wdat});
        unlock(stored_password_in);
        wait_hi(0);
        exp_q.push_back({3'b001, def[7:1], wdat[0]});
        send('{OP_RESET_ENABLE});
        send('{OP_SOFT_RESET});
        wait_hi(0);
        fur_host_model_inst.frame('{OP_WAKE_AND_ID, 8'h00, 8'h00, 8'h00}, 1, rd);
        check_val(11'(rd), 11'(ID_VAL));
        quad_command_mode_in <= 1'b0;
        send('{8'h00});
        send('{OP_DEEP_SLEEP});
        wait_hi(2);
        send('{8'h05});
        check_val(11'(deep_sleep_out), 11'h001);
        exp_q.push_back({3'b001, def[7:1], wdat[0]});
        send('{OP_WAKE_AND_ID});
        wait_hi(0);
        send('{OP_DEEP_SLEEP});
        wait_hi(2);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        exp_q.push_back({3'b000, def});
        wait_hi(0);
        check_val(11'(deep_sleep_out), 11'h000);
        stop_test();
    end
endmodule
